// ==== pkg/swa_pkg.sv ====
//==============================================================
// Socket window address register constants
package swa_pkg;

    localparam int NUM_MEM_WIN = 5;
    localparam int NUM_IO_WIN = 2;

    //==========================================================
    // Register offsets from the socket base
    localparam logic [11:0] IO_WIN0_END_HIGH_OFS = 12'h80b;
    localparam logic [11:0] IO_WIN1_END_HIGH_OFS = 12'h80f;
    localparam logic [4:0][11:0] MEM_START_LOW_OFS = {
        12'h830, 12'h828, 12'h820, 12'h818, 12'h810};
    localparam logic [4:0][11:0] MEM_START_HIGH_OFS = {
        12'h831, 12'h829, 12'h821, 12'h819, 12'h811};

    //==========================================================
    // Start high byte fields
    localparam int WIDTH_SEL_BIT = 7;
    localparam int FAST_SEL_BIT = 6;
    localparam int SCRATCH_MSB = 5;
    localparam int SCRATCH_LSB = 4;
    localparam int NIBBLE_MSB = 3;
    localparam int NIBBLE_LSB = 0;

    //==========================================================
    // Reset value and read filler
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    //==========================================================
    // Card address slice compared by a window
    localparam int CARD_ADDR_MSB = 23;
    localparam int CARD_ADDR_LSB = 12;

    //==========================================================
    // Cycle length codes, in ISA cycles; zero means standard
    localparam logic [1:0] CYC_STD = 2'h0;
    localparam logic [1:0] CYC_FAST8 = 2'h3;
    localparam logic [1:0] CYC_FAST16 = 2'h2;

endpackage : swa_pkg

// ==== hw/swa_win_match.sv ====
`timescale 1ns/10ps
//==============================================================
// Memory window range match
module swa_win_match (
    input wire logic [4:0][11:0] winStart,
    input wire logic [4:0][11:0] winEnd,
    input wire logic [11:0] cardAddr,
    output logic hit,
    output logic [2:0] winIdx
);

    function automatic logic in_window(
        input logic [11:0] addr,
        input logic [11:0] lo,
        input logic [11:0] hi
    );
        in_window = (addr >= lo) && (addr <= hi);
    endfunction : in_window

    // Lowest numbered window wins on overlap
    always_comb begin
        hit = 1'b0;
        winIdx = 3'h0;
        for (int i = swa_pkg::NUM_MEM_WIN - 1; i >= 0; i--) begin
            if (in_window(cardAddr, winStart[i], winEnd[i])) begin
                hit = 1'b1;
                winIdx = 3'(i);
            end
        end
    end

endmodule : swa_win_match

// ==== hw/swa_socket_window_regs.sv ====
`timescale 1ns/10ps
//==============================================================
// Contract
// - Each I/O window has an 8-bit end high register holding the top byte of its end.
// - The I/O window 0 and 1 end high registers sit at base plus 80Bh and 80Fh.
// - Five memory windows each have a start low register at 810h, 818h, 820h, 828h, 830h.
// - A start low register gives card address bits A19 to A12 of its window start.
// - All start low bits are read/write and reset to 00h.
// - Start high bits 3 to 0 give card address bits A23 to A20 of the window start.
// - Start high bit 7 picks 8-bit transfers when clear and 16-bit when set.
// - Start high bit 6 set shortens 8-bit cycles to three ISA cycles and 16-bit to two.
// - Start high bits 5 and 4 are plain read/write storage with no effect.
// - Start high registers sit at 811h, 819h, 821h, 829h, 831h and reset to 00h.
module swa_socket_window_regs (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [11:0] cpuAddr,
    input wire logic cpuWrEn,
    input wire logic [7:0] cpuWrData,
    input wire logic cpuRdEn,
    output logic [7:0] cpuRdData,
    output logic cpuRdValid,
    output logic [7:0] ioWin0EndHigh,
    output logic [7:0] ioWin1EndHigh,
    output logic [4:0][11:0] memWinStart,
    output logic [4:0] windowWidthSelect,
    output logic [4:0] fastCycleSelect,
    input wire logic [4:0][11:0] memWinEnd,
    input wire logic accReq,
    input wire logic [23:0] accAddr,
    output logic accDone,
    output logic accHit,
    output logic [2:0] accWin,
    output logic accWidth16,
    output logic [1:0] accCycles
);

    //==========================================================
    // State
    typedef struct packed {
        logic [1:0][7:0] ioEndHi;
        logic [4:0][7:0] memStartLo;
        logic [4:0][7:0] memStartHi;
        logic [7:0] rdData;
        logic rdValid;
        logic accDone;
        logic accHit;
        logic [2:0] accWin;
        logic accWidth16;
        logic [1:0] accCycles;
    } swa_state_t;

    swa_state_t state_ff;
    swa_state_t nxt_state;
    logic [4:0][11:0] startAddr;
    logic matchHit;
    logic [2:0] matchWin;

    //==========================================================
    // Register read mux
    function automatic logic [7:0] read_byte(
        input swa_state_t st,
        input logic [11:0] addr
    );
        read_byte = swa_pkg::UNMAPPED_READ;
        if (addr == swa_pkg::IO_WIN0_END_HIGH_OFS) begin
            read_byte = st.ioEndHi[0];
        end
        if (addr == swa_pkg::IO_WIN1_END_HIGH_OFS) begin
            read_byte = st.ioEndHi[1];
        end
        for (int i = 0; i < swa_pkg::NUM_MEM_WIN; i++) begin
            if (addr == swa_pkg::MEM_START_LOW_OFS[i]) begin
                read_byte = st.memStartLo[i];
            end
            if (addr == swa_pkg::MEM_START_HIGH_OFS[i]) begin
                read_byte = st.memStartHi[i];
            end
        end
    endfunction : read_byte

    //==========================================================
    // Window start addresses
    always_comb begin
        for (int i = 0; i < swa_pkg::NUM_MEM_WIN; i++) begin
            startAddr[i] = {state_ff.memStartHi[i][swa_pkg::NIBBLE_MSB:swa_pkg::NIBBLE_LSB],
                state_ff.memStartLo[i]};
        end
    end

    swa_win_match u_match (
        .winStart(startAddr),
        .winEnd(memWinEnd),
        .cardAddr(accAddr[swa_pkg::CARD_ADDR_MSB:swa_pkg::CARD_ADDR_LSB]),
        .hit(matchHit),
        .winIdx(matchWin)
    );

    //==========================================================
    // Next state
    always_comb begin
        nxt_state = state_ff;
        nxt_state.rdValid = 1'b0;
        nxt_state.accDone = 1'b0;
        // Read sees the value before a same-cycle write
        if (cpuRdEn) begin
            nxt_state.rdValid = 1'b1;
            nxt_state.rdData = read_byte(state_ff, cpuAddr);
        end
        if (cpuWrEn) begin
            if (cpuAddr == swa_pkg::IO_WIN0_END_HIGH_OFS) begin
                nxt_state.ioEndHi[0] = cpuWrData;
            end
            if (cpuAddr == swa_pkg::IO_WIN1_END_HIGH_OFS) begin
                nxt_state.ioEndHi[1] = cpuWrData;
            end
            for (int i = 0; i < swa_pkg::NUM_MEM_WIN; i++) begin
                if (cpuAddr == swa_pkg::MEM_START_LOW_OFS[i]) begin
                    nxt_state.memStartLo[i] = cpuWrData;
                end
                if (cpuAddr == swa_pkg::MEM_START_HIGH_OFS[i]) begin
                    nxt_state.memStartHi[i] = cpuWrData;
                end
            end
        end
        if (accReq) begin
            nxt_state.accDone = 1'b1;
            nxt_state.accHit = matchHit;
            nxt_state.accWin = matchWin;
            nxt_state.accWidth16 = 1'b0;
            nxt_state.accCycles = swa_pkg::CYC_STD;
            if (matchHit) begin
                nxt_state.accWidth16 =
                    state_ff.memStartHi[matchWin][swa_pkg::WIDTH_SEL_BIT];
                if (state_ff.memStartHi[matchWin][swa_pkg::FAST_SEL_BIT]) begin
                    if (state_ff.memStartHi[matchWin][swa_pkg::WIDTH_SEL_BIT]) begin
                        nxt_state.accCycles = swa_pkg::CYC_FAST16;
                    end else begin
                        nxt_state.accCycles = swa_pkg::CYC_FAST8;
                    end
                end
            end
        end
        if (!reset_n) begin
            nxt_state = '0;
            nxt_state.ioEndHi = {2{swa_pkg::REG_RESET}};
            nxt_state.memStartLo = {5{swa_pkg::REG_RESET}};
            nxt_state.memStartHi = {5{swa_pkg::REG_RESET}};
            nxt_state.accCycles = swa_pkg::CYC_STD;
        end
    end

    always_ff @(posedge sys_clk) begin
        state_ff <= nxt_state;
    end

    //==========================================================
    // Outputs
    assign cpuRdData = state_ff.rdData;
    assign cpuRdValid = state_ff.rdValid;
    assign ioWin0EndHigh = state_ff.ioEndHi[0];
    assign ioWin1EndHigh = state_ff.ioEndHi[1];
    assign memWinStart = startAddr;
    assign accDone = state_ff.accDone;
    assign accHit = state_ff.accHit;
    assign accWin = state_ff.accWin;
    assign accWidth16 = state_ff.accWidth16;
    assign accCycles = state_ff.accCycles;

    always_comb begin
        for (int i = 0; i < swa_pkg::NUM_MEM_WIN; i++) begin
            windowWidthSelect[i] = state_ff.memStartHi[i][swa_pkg::WIDTH_SEL_BIT];
            fastCycleSelect[i] = state_ff.memStartHi[i][swa_pkg::FAST_SEL_BIT];
        end
    end

    //==========================================================
    // Checks
    property p_io0_end;
        @(posedge sys_clk) disable iff (!reset_n)
        (cpuWrEn && cpuAddr == 12'h80b) |=> (ioWin0EndHigh == $past(cpuWrData));
    endproperty
    a_io0_end: assert property (p_io0_end)
        else $error("I/O window 0 end high not written");

    property p_io1_readback;
        @(posedge sys_clk) disable iff (!reset_n)
        (cpuWrEn && cpuAddr == 12'h80f) ##1 (cpuRdEn && !cpuWrEn && cpuAddr == 12'h80f)
            |=> (cpuRdValid && cpuRdData == $past(cpuWrData, 2));
    endproperty
    a_io1_readback: assert property (p_io1_readback)
        else $error("I/O window 1 end high readback wrong");

    property p_low4_write;
        @(posedge sys_clk) disable iff (!reset_n)
        (cpuWrEn && cpuAddr == 12'h830) |=> (memWinStart[4][7:0] == $past(cpuWrData));
    endproperty
    a_low4_write: assert property (p_low4_write)
        else $error("Window 4 start low not written");

    property p_low_addr;
        @(posedge sys_clk) disable iff (!reset_n)
        (cpuWrEn && cpuAddr == 12'h818) |=> (memWinStart[1][7:0] == $past(cpuWrData)
            && memWinStart[1][11:8] == $past(memWinStart[1][11:8]));
    endproperty
    a_low_addr: assert property (p_low_addr)
        else $error("Start low does not map to A19-A12");

    property p_low_readback;
        @(posedge sys_clk) disable iff (!reset_n)
        (cpuWrEn && cpuAddr == 12'h820) ##1 (cpuRdEn && !cpuWrEn && cpuAddr == 12'h820)
            |=> (cpuRdData == $past(cpuWrData, 2));
    endproperty
    a_low_readback: assert property (p_low_readback)
        else $error("Start low readback wrong");

    property p_high_nibble;
        @(posedge sys_clk) disable iff (!reset_n)
        (cpuWrEn && cpuAddr == 12'h811) |=> (memWinStart[0][11:8] == $past(cpuWrData[3:0]));
    endproperty
    a_high_nibble: assert property (p_high_nibble)
        else $error("Start nibble does not map to A23-A20");

    property p_width_bit;
        @(posedge sys_clk) disable iff (!reset_n)
        (cpuWrEn && cpuAddr == 12'h819) |=> (windowWidthSelect[1] == $past(cpuWrData[7]));
    endproperty
    a_width_bit: assert property (p_width_bit)
        else $error("Width select not taken from bit 7");

    property p_fast_cycles;
        @(posedge sys_clk) disable iff (!reset_n)
        (accDone && accCycles != 2'h0) |-> (accHit
            && accCycles == (accWidth16 ? 2'h2 : 2'h3));
    endproperty
    a_fast_cycles: assert property (p_fast_cycles)
        else $error("Shortened cycle count wrong");

    property p_scratch_inert;
        @(posedge sys_clk) disable iff (!reset_n)
        (cpuWrEn && cpuAddr == 12'h821 && cpuWrData[7:6] == state_ff.memStartHi[2][7:6])
            |=> ($stable(windowWidthSelect) && $stable(fastCycleSelect));
    endproperty
    a_scratch_inert: assert property (p_scratch_inert)
        else $error("Scratch bits changed window behaviour");

    property p_reset_zero;
        @(posedge sys_clk)
        !reset_n |=> (windowWidthSelect == 5'h00 && fastCycleSelect == 5'h00
            && memWinStart == 60'h0 && ioWin0EndHigh == 8'h00 && !accDone);
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("Registers not cleared by reset");

    property p_miss_default;
        @(posedge sys_clk) disable iff (!reset_n)
        accReq |=> (accDone && (accHit || (!accWidth16 && accCycles == 2'h0)));
    endproperty
    a_miss_default: assert property (p_miss_default)
        else $error("Miss carried window settings");

    property p_io1_end;
        @(posedge sys_clk) disable iff (!reset_n)
        (cpuWrEn && cpuAddr == 12'h80f) |=> (ioWin1EndHigh == $past(cpuWrData));
    endproperty
    a_io1_end: assert property (p_io1_end)
        else $error("I/O window 1 end high not written");

    property p_low0_write;
        @(posedge sys_clk) disable iff (!reset_n)
        (cpuWrEn && cpuAddr == 12'h810) |=> (memWinStart[0][7:0] == $past(cpuWrData));
    endproperty
    a_low0_write: assert property (p_low0_write)
        else $error("Window 0 start low not written");

    property p_unmapped_read;
        @(posedge sys_clk) disable iff (!reset_n)
        (cpuRdEn && cpuAddr == 12'h812) |=> (cpuRdValid && cpuRdData == 8'h00);
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("Unmapped offset did not read zero");

    property p_unmapped_write;
        @(posedge sys_clk) disable iff (!reset_n)
        (cpuWrEn && cpuAddr == 12'h812) |=> ($stable(memWinStart) && $stable(ioWin0EndHigh)
            && $stable(ioWin1EndHigh));
    endproperty
    a_unmapped_write: assert property (p_unmapped_write)
        else $error("Unmapped write changed a register");

    property p_rd_valid;
        @(posedge sys_clk) disable iff (!reset_n)
        cpuRdEn |=> cpuRdValid;
    endproperty
    a_rd_valid: assert property (p_rd_valid)
        else $error("Read not answered one cycle later");

    property p_rd_pulse;
        @(posedge sys_clk) disable iff (!reset_n)
        !cpuRdEn |=> !cpuRdValid;
    endproperty
    a_rd_pulse: assert property (p_rd_pulse)
        else $error("Read valid without a read");

    property p_high4_nibble;
        @(posedge sys_clk) disable iff (!reset_n)
        (cpuWrEn && cpuAddr == 12'h831) |=> (memWinStart[4][11:8] == $past(cpuWrData[3:0]));
    endproperty
    a_high4_nibble: assert property (p_high4_nibble)
        else $error("Window 4 start high not written");

    property p_fast_bit;
        @(posedge sys_clk) disable iff (!reset_n)
        (cpuWrEn && cpuAddr == 12'h829) |=> (fastCycleSelect[3] == $past(cpuWrData[6]));
    endproperty
    a_fast_bit: assert property (p_fast_bit)
        else $error("Fast select not taken from bit 6");

    property p_miss_clear;
        @(posedge sys_clk) disable iff (!reset_n)
        (accDone && !accHit) |-> (accWin == 3'h0 && !accWidth16 && accCycles == 2'h0);
    endproperty
    a_miss_clear: assert property (p_miss_clear)
        else $error("Miss answer not cleared");

    property p_hit_width;
        @(posedge sys_clk) disable iff (!reset_n)
        (accReq && !cpuWrEn) |=> (!accHit || accWidth16 == windowWidthSelect[accWin]);
    endproperty
    a_hit_width: assert property (p_hit_width)
        else $error("Hit width differs from window setting");

    property p_hit_range;
        @(posedge sys_clk) disable iff (!reset_n)
        ((accReq && !cpuWrEn) ##1 $stable(memWinEnd)) |-> (!accHit
            || ($past(accAddr[23:12]) >= memWinStart[accWin]
            && $past(accAddr[23:12]) <= memWinEnd[accWin]));
    endproperty
    a_hit_range: assert property (p_hit_range)
        else $error("Hit outside window range");

endmodule : swa_socket_window_regs

// ==== sim/swa_card_model.sv ====
`timescale 1ns/10ps
//==============================================================
// Card side: window end addresses and lookup requests
module swa_card_model (
    input wire logic sys_clk,
    output logic [4:0][11:0] memWinEnd,
    output logic accReq,
    output logic [23:0] accAddr
);
    initial begin
        memWinEnd = '0;
        accReq = 1'b0;
        accAddr = 24'h000000;
    end

    task automatic set_end(input int idx, input logic [11:0] endVal);
        @(negedge sys_clk);
        memWinEnd[idx] = endVal;
    endtask : set_end

    task automatic lookup(input logic [23:0] addr);
        @(negedge sys_clk);
        accReq = 1'b1;
        accAddr = addr;
        @(negedge sys_clk);
        accReq = 1'b0;
        // Released address must not look like the last one
        accAddr = ~addr;
    endtask : lookup
endmodule : swa_card_model

// ==== sim/swa_socket_window_regs_bench.sv ====
`timescale 1ns/10ps
//==============================================================
// Register bank bench
module swa_socket_window_regs_bench;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [11:0] cpuAddr = 12'h000;
    logic cpuWrEn = 1'b0;
    logic [7:0] cpuWrData = 8'h00;
    logic cpuRdEn = 1'b0;
    logic [7:0] cpuRdData;
    logic cpuRdValid;
    logic [7:0] ioWin0EndHigh;
    logic [7:0] ioWin1EndHigh;
    logic [4:0][11:0] memWinStart;
    logic [4:0] windowWidthSelect;
    logic [4:0] fastCycleSelect;
    logic [4:0][11:0] memWinEnd;
    logic accReq;
    logic [23:0] accAddr;
    logic accDone;
    logic accHit;
    logic [2:0] accWin;
    logic accWidth16;
    logic [1:0] accCycles;
    int fail_count = 0;
    int num_checks = 0;
    logic [11:0] ofs [12];
    logic [7:0] cfg [5] = '{8'h00, 8'h80, 8'hc0, 8'h40, 8'h30};
    logic [7:0] lowSel [4] = '{8'h40, 8'h7f, 8'h80, 8'h3f};

    always #4 sys_clk = ~sys_clk;

    swa_socket_window_regs DUT (.sys_clk(sys_clk), .reset_n(reset_n), .cpuAddr(cpuAddr),
        .cpuWrEn(cpuWrEn), .cpuWrData(cpuWrData), .cpuRdEn(cpuRdEn), .cpuRdData(cpuRdData),
        .cpuRdValid(cpuRdValid), .ioWin0EndHigh(ioWin0EndHigh), .ioWin1EndHigh(ioWin1EndHigh),
        .memWinStart(memWinStart), .windowWidthSelect(windowWidthSelect),
        .fastCycleSelect(fastCycleSelect), .memWinEnd(memWinEnd), .accReq(accReq),
        .accAddr(accAddr), .accDone(accDone), .accHit(accHit), .accWin(accWin),
        .accWidth16(accWidth16), .accCycles(accCycles));

    swa_card_model CARD (.sys_clk(sys_clk), .memWinEnd(memWinEnd), .accReq(accReq),
        .accAddr(accAddr));

    //==========================================================
    // Access and compare tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        cpuAddr = a;
        cpuWrData = d;
        cpuWrEn = 1'b1;
        @(negedge sys_clk);
        cpuWrEn = 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(negedge sys_clk);
        cpuAddr = a;
        cpuRdEn = 1'b1;
        @(negedge sys_clk);
        cpuRdEn = 1'b0;
        check(32'(cpuRdValid), 32'h1, "read valid");
        check(32'(cpuRdData), 32'(exp), "read data");
    endtask : rd

    task automatic final_report;
        if (fail_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report

    function automatic logic [7:0] pat(input int k);
        return 8'(k * 29 + 8'h5a);
    endfunction : pat

    //==========================================================
    // Watchdog
    initial begin
        #(5000 * 8);
        fail_count++;
        final_report();
    end

    //==========================================================
    // Main sequence
    initial begin
        logic [11:0] endVal;
        logic [23:0] a;
        logic [7:0] h;
        ofs[0] = swa_pkg::IO_WIN0_END_HIGH_OFS;
        ofs[1] = swa_pkg::IO_WIN1_END_HIGH_OFS;
        for (int i = 0; i < 5; i++) begin
            ofs[2 + 2 * i] = swa_pkg::MEM_START_LOW_OFS[i];
            ofs[3 + 2 * i] = swa_pkg::MEM_START_HIGH_OFS[i];
        end
        repeat (3) @(negedge sys_clk);
        reset_n = 1'b1;
        for (int k = 0; k < 12; k++) begin
            rd(ofs[k], 8'h00);
        end
        for (int k = 0; k < 12; k++) begin
            wr(ofs[k], pat(k));
        end
        for (int k = 0; k < 12; k++) begin
            rd(ofs[k], pat(k));
        end
        check(32'(ioWin0EndHigh), 32'(pat(0)), "io end 0");
        check(32'(ioWin1EndHigh), 32'(pat(1)), "io end 1");
        for (int i = 0; i < 5; i++) begin
            h = pat(3 + 2 * i);
            check(32'(memWinStart[i]), 32'({h[3:0], pat(2 + 2 * i)}), "start");
            check(32'(windowWidthSelect[i]), 32'(h[7]), "width");
            check(32'(fastCycleSelect[i]), 32'(h[6]), "fast");
        end
        // Unmapped neighbours read zero and change nothing
        wr(12'h812, 8'hff);
        rd(12'h812, swa_pkg::UNMAPPED_READ);
        rd(12'h80a, swa_pkg::UNMAPPED_READ);
        rd(ofs[2], pat(2));
        // Same-edge read and write returns the old value
        @(negedge sys_clk);
        cpuAddr = ofs[2];
        cpuWrData = 8'h3c;
        cpuWrEn = 1'b1;
        cpuRdEn = 1'b1;
        @(negedge sys_clk);
        cpuWrEn = 1'b0;
        cpuRdEn = 1'b0;
        check(32'(cpuRdData), 32'(pat(2)), "old value");
        rd(ofs[2], 8'h3c);
        // Back-to-back write then read of one offset
        for (int k = 0; k < 2; k++) begin
            @(negedge sys_clk);
            cpuAddr = (k == 0) ? swa_pkg::IO_WIN1_END_HIGH_OFS : swa_pkg::MEM_START_LOW_OFS[2];
            cpuWrData = 8'(8'ha5 + k);
            cpuWrEn = 1'b1;
            @(negedge sys_clk);
            cpuWrEn = 1'b0;
            cpuRdEn = 1'b1;
            @(negedge sys_clk);
            cpuRdEn = 1'b0;
            check(32'(cpuRdData), 32'(8'(8'ha5 + k)), "back to back");
        end
        // Window lookup: start {i+1,40}, end {i+1,7f}
        for (int i = 0; i < 5; i++) begin
            wr(swa_pkg::MEM_START_LOW_OFS[i], 8'h40);
            wr(swa_pkg::MEM_START_HIGH_OFS[i], cfg[i] | 8'(i + 1));
            endVal = {4'(i + 1), 8'h7f};
            CARD.set_end(i, endVal);
        end
        for (int i = 0; i < 5; i++) begin
            for (int k = 0; k < 4; k++) begin
                a = {4'(i + 1), lowSel[k], (k % 2 == 1) ? 12'hfff : 12'h000};
                CARD.lookup(a);
                h = (k < 2) ? cfg[i] : 8'h00;
                check(32'(accDone), 32'h1, "done");
                check(32'(accHit), 32'(k < 2), "hit");
                check(32'(accWin), (k < 2) ? 32'(i) : 32'h0, "win");
                check(32'(accWidth16), 32'(h[7]), "width16");
                check(32'(accCycles), !h[6] ? 32'(swa_pkg::CYC_STD) : h[7] ?
                    32'(swa_pkg::CYC_FAST16) : 32'(swa_pkg::CYC_FAST8), "cycles");
            end
        end
        // Reset in mid-run clears the bank
        @(negedge sys_clk);
        reset_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        reset_n = 1'b1;
        for (int i = 0; i < 5; i++) begin
            check(32'(memWinStart[i]), 32'h0, "start after reset");
            check(32'(windowWidthSelect[i] | fastCycleSelect[i]), 32'h0, "flags");
        end
        check(32'({ioWin1EndHigh, ioWin0EndHigh}), 32'h0, "io end after reset");
        rd(swa_pkg::MEM_START_HIGH_OFS[2], swa_pkg::REG_RESET);
        final_report();
    end
endmodule : swa_socket_window_regs_bench
